// >>> hw/gpio_port.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Channel select bit picks event channel A or B.
// R2 - Polarity bit sets interrupt trigger level.
// R3 - Events driven out at polarity active level.
// R4 - Polarity also sets timer clear input level.
// R5 - Event enable bit lets compare events out.
// R6 - Event enable forces output, buffer type kept.
// R7 - Buffer bit: 0 open-drain, 1 push-pull.
// R8 - Open-drain data: low on 0, released on 1.
// R9 - Open-drain events follow polarity drive table.
// R10 - Direction bit: 0 input, 1 output.
// R11 - Output pin drives written data bit.
// R12 - Data read: live pin if input, else written.
// R13 - Direction bits reset to zero.
// R14 - Interrupt inputs must hold level over 40 ns.
// R15 - Writing one clears interrupt status flag.
// R16 - Undirected, non-event pins stay undriven.
module gpio_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] event_chan_a,
    input wire logic [7:0] event_chan_b,
    output logic [7:0] timer_clear,
    output logic irq,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    gpio_pkg::pin_config_t cfg_q;
    logic [7:0] dir_q;
    logic [7:0] data_q;
    logic [7:0] int_en_q;
    logic [7:0] int_sts_q;
    logic [7:0] int_sts_d;
    logic [31:0] reg_rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] sync3_q;
    logic [7:0] pin_level_q;
    logic [7:0] pin_out_q;
    logic [7:0] pin_oe_q;
    logic [7:0] timer_clear_q;

    // Register map: three words at fixed byte addresses, matched exactly.
    // The configuration word holds channel select, polarity, event output
    // enable and buffer type, one byte each, from the top down. The data and
    // direction word holds the directions in its third byte and the data in
    // its low byte. The interrupt word holds the enables in its third byte
    // and the sticky status flags in its low byte. Other bits read as zero.
    // Every access completes in one cycle; the bus never waits.
    wire sel_cfg = reg_addr == gpio_pkg::pin_config_addr;
    wire sel_dd = reg_addr == gpio_pkg::pin_data_direction_addr;
    wire sel_int = reg_addr == gpio_pkg::pin_interrupt_status_enable_addr;
    wire wr_cfg = reg_write && sel_cfg;
    wire wr_dd = reg_write && sel_dd;
    wire wr_int = reg_write && sel_int;

    // Write data split into the fields of each register.
    wire [7:0] wdata_direction = reg_wdata[gpio_pkg::direction_lsb +: 8];
    wire [7:0] wdata_data = reg_wdata[gpio_pkg::data_lsb +: 8];
    wire [7:0] wdata_int_enable = reg_wdata[gpio_pkg::int_enable_lsb +: 8];
    wire [7:0] wdata_int_clear = reg_wdata[gpio_pkg::int_status_lsb +: 8];

    // Event inputs come from logic on this clock, so they skip the
    // synchroniser and reach the pins one cycle later.
    // Per-pin event source, chosen by channel.
    wire [7:0] event_raw = (cfg_q.event_channel_select & event_chan_b)
                         | (~cfg_q.event_channel_select & event_chan_a); // R1
    wire [7:0] event_on = event_raw & cfg_q.event_output_enable; // R5
    // Active level follows polarity: polarity 0 means an event shows as low.
    wire [7:0] event_level = ~(event_on ^ cfg_q.pin_polarity); // R3

    // A pin drives when it is a direction output or an event output; the
    // event enable overrides the direction bit but not the buffer type.
    wire [7:0] drives = dir_q | cfg_q.event_output_enable; // R6 R10 R16
    wire [7:0] level = (cfg_q.event_output_enable & event_level)
                     | (~cfg_q.event_output_enable & data_q); // R11

    // Push-pull drives both levels. Open-drain drives only a low level and
    // releases a high one, which for event pins gives the polarity table:
    // polarity 0 pulls low during an event, polarity 1 pulls low between
    // events. The pin then relies on the board pull-up for its high level.
    wire [7:0] push_pull = cfg_q.pin_buffer_type; // R7
    wire [7:0] open_drain = ~cfg_q.pin_buffer_type; // R7
    wire [7:0] oe_push_pull = drives & push_pull;
    wire [7:0] oe_open_drain = drives & open_drain & ~level; // R8 R9
    wire [7:0] oe_d = oe_push_pull | oe_open_drain;
    wire [7:0] out_d = level & push_pull;

    // Pin matches its polarity: a level-sensitive trigger.
    wire [7:0] pin_active = ~(pin_level_q ^ cfg_q.pin_polarity); // R2 R4
    // An output pin reads back what was written, not the pad, so a loaded
    // open-drain line does not read back as its own data.
    wire [7:0] data_read = (drives & data_q) | (~drives & pin_level_q); // R12

    // Three-stage synchroniser on the asynchronous pad inputs. Only the
    // second stage reads the first, so a metastable first stage never
    // reaches the decision logic.
    stage_reg #(.width(gpio_pkg::num_pins)) sync1 (
        .clk(clk),
        .reset_n(reset_n),
        .d(pin_in),
        .q(sync1_q)
    );

    stage_reg #(.width(gpio_pkg::num_pins)) sync2 (
        .clk(clk),
        .reset_n(reset_n),
        .d(sync1_q),
        .q(sync2_q)
    );

    stage_reg #(.width(gpio_pkg::num_pins)) sync3 (
        .clk(clk),
        .reset_n(reset_n),
        .d(sync2_q),
        .q(sync3_q)
    );

    // A change counts only once stages two and three agree, so a pulse of
    // about one cycle is lost. Interrupt sources must hold their level for
    // several clock periods to be seen.
    wire [7:0] stages_agree = ~(sync2_q ^ sync3_q);
    wire [7:0] pin_level_d = (stages_agree & sync2_q) | (~stages_agree & pin_level_q);

    // The filtered level resets low, so with polarity zero every pin flags
    // once after reset; software clears the status before it enables irq.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_level_q <= gpio_pkg::pins_reset;
        end else begin
            pin_level_q <= pin_level_d;
        end
    end

    // Software fields load on their strobe and reset to zero.
    field_reg #(.width($bits(gpio_pkg::pin_config_t))) cfg_field (
        .clk(clk),
        .reset_n(reset_n),
        .load(wr_cfg),
        .d(reg_wdata),
        .q(cfg_q)
    );

    field_reg #(.width(gpio_pkg::num_pins)) dir_field (
        .clk(clk),
        .reset_n(reset_n),
        .load(wr_dd),
        .d(wdata_direction),
        .q(dir_q) // R13
    );

    field_reg #(.width(gpio_pkg::num_pins)) data_field (
        .clk(clk),
        .reset_n(reset_n),
        .load(wr_dd),
        .d(wdata_data),
        .q(data_q)
    );

    field_reg #(.width(gpio_pkg::num_pins)) int_en_field (
        .clk(clk),
        .reset_n(reset_n),
        .load(wr_int),
        .d(wdata_int_enable),
        .q(int_en_q)
    );

    // Writing one clears a flag, but a pin still at its trigger level sets
    // it again in the same cycle: the set wins so no event is lost.
    wire [7:0] status_clear = wr_int ? wdata_int_clear : gpio_pkg::pins_reset; // R15
    wire [7:0] status_set = pin_active; // R2
    assign int_sts_d = (int_sts_q & ~status_clear) | status_set;

    // Status flags record events whether or not they are enabled.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_sts_q <= gpio_pkg::pins_reset;
        end else begin
            int_sts_q <= int_sts_d;
        end
    end

    // Reserved bits and unmapped addresses read as zero.
    always_comb begin
        rdata_d = gpio_pkg::read_zero;
        if (sel_cfg) begin
            rdata_d = cfg_q;
        end else if (sel_dd) begin
            rdata_d[gpio_pkg::direction_lsb +: 8] = dir_q;
            rdata_d[gpio_pkg::data_lsb +: 8] = data_read; // R12
        end else if (sel_int) begin
            rdata_d[gpio_pkg::int_enable_lsb +: 8] = int_en_q;
            rdata_d[gpio_pkg::int_status_lsb +: 8] = int_sts_q;
        end
    end

    // Read data stands for the one cycle after the strobe and is zero
    // otherwise, so a stale word cannot pass for a fresh answer.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_q <= gpio_pkg::read_zero;
        end else begin
            reg_rdata_q <= reg_read ? rdata_d : gpio_pkg::read_zero;
        end
    end

    // Pin drivers are registered so that a decode glitch never reaches a
    // pad; the price is one cycle of latency from a write to the pin.
    stage_reg #(.width(gpio_pkg::num_pins)) out_stage (
        .clk(clk),
        .reset_n(reset_n),
        .d(out_d),
        .q(pin_out_q)
    );

    stage_reg #(.width(gpio_pkg::num_pins)) oe_stage (
        .clk(clk),
        .reset_n(reset_n),
        .d(oe_d),
        .q(pin_oe_q)
    );

    // Timer clear requests follow the filtered pin at its polarity level,
    // so they carry the same synchroniser delay as the interrupt flags.
    stage_reg #(.width(gpio_pkg::num_pins)) clear_stage (
        .clk(clk),
        .reset_n(reset_n),
        .d(pin_active), // R4
        .q(timer_clear_q)
    );

    // The interrupt is a level: a flag set while masked raises irq as soon
    // as its enable bit is written.
    assign reg_rdata = reg_rdata_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign timer_clear = timer_clear_q;
    assign irq = |(int_sts_q & int_en_q);

endmodule : gpio_port

// Small building blocks used above; each is a bank of rising-edge flops
// with a synchronous, active-low reset to zero.
// One register stage of a synchroniser or an output pipeline.
module stage_reg #(
    parameter int unsigned width = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [width-1:0] d,
    output logic [width-1:0] q
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : stage_reg

// A software field that loads on its write strobe and otherwise holds.
// Sharing one strobe keeps the fields of a word updated together.
module field_reg #(
    parameter int unsigned width = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [width-1:0] d,
    output logic [width-1:0] q
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else if (load) begin
            q <= d;
        end
    end
endmodule : field_reg

// >>> hw/gpio_pkg.sv
package gpio_pkg;
    localparam int unsigned num_pins = 8;
    localparam int unsigned addr_width = 12;

    localparam logic [11:0] pin_config_addr = 12'h1E0;
    localparam logic [11:0] pin_data_direction_addr = 12'h1E4;
    localparam logic [11:0] pin_interrupt_status_enable_addr = 12'h1E8;

    localparam int unsigned chan_sel_lsb = 24;
    localparam int unsigned polarity_lsb = 16;
    localparam int unsigned event_oe_lsb = 8;
    localparam int unsigned buffer_lsb = 0;
    localparam int unsigned direction_lsb = 16;
    localparam int unsigned data_lsb = 0;
    localparam int unsigned int_enable_lsb = 16;
    localparam int unsigned int_status_lsb = 0;

    localparam logic [7:0] pins_reset = 8'h00;
    localparam logic [31:0] read_zero = 32'h0000_0000;

    localparam int unsigned sync_stages = 3;

    typedef struct packed {
        logic [7:0] event_channel_select;
        logic [7:0] pin_polarity;
        logic [7:0] event_output_enable;
        logic [7:0] pin_buffer_type;
    } pin_config_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] in;
    } pin_bus_t;
endpackage : gpio_pkg

// >>> dv/gpio_port_asserts.sv
`timescale 1ns/10ps
module gpio_port_asserts (
    input wire logic clk, reset_n, reg_write, reg_read, irq,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata,
    input wire logic [7:0] event_chan_a, event_chan_b, timer_clear, pin_in, pin_out, pin_oe
);
    logic [31:0] cfg_q, dd_q;
    logic [7:0] ie_q;
    wire logic [7:0] ev = (cfg_q[31:24] & event_chan_b) | (~cfg_q[31:24] & event_chan_a);
    wire logic [7:0] eo = cfg_q[15:8];
    wire logic [7:0] dir = dd_q[23:16];
    wire logic [7:0] drv = dir | eo;
    wire logic [7:0] lvl = (eo & ~(ev ^ cfg_q[23:16])) | (~eo & dd_q[7:0]);
    wire logic [7:0] x_oe = drv & (cfg_q[7:0] | ~lvl);
    wire logic [7:0] x_out = cfg_q[7:0] & lvl;
    wire logic [7:0] x_dat = drv & dd_q[7:0];
    wire logic rd0 = reg_read && reg_addr == 12'h1E0;
    wire logic rd1 = reg_read && reg_addr == 12'h1E4;
    always_ff @(posedge clk) begin
        cfg_q <= !reset_n ? '0 : (reg_write && reg_addr == 12'h1E0) ? reg_wdata : cfg_q;
        dd_q <= !reset_n ? '0 : (reg_write && reg_addr == 12'h1E4) ? reg_wdata : dd_q;
        ie_q <= !reset_n ? '0 : (reg_write && reg_addr == 12'h1E8) ? reg_wdata[23:16] : ie_q;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_oe; pin_oe == $past(x_oe); endproperty
    a_oe: assert property (p_oe) else $error("bad oe");
    property p_out; pin_out == $past(x_out); endproperty
    a_out: assert property (p_out) else $error("bad out");
    property p_cfg; rd0 |=> reg_rdata == $past(cfg_q); endproperty
    a_cfg: assert property (p_cfg) else $error("bad cfg");
    property p_dir; rd1 |=> reg_rdata[23:16] == $past(dir); endproperty
    a_dir: assert property (p_dir) else $error("bad dir");
    property p_dat; rd1 |=> (reg_rdata[7:0] & $past(drv)) == $past(x_dat); endproperty
    a_dat: assert property (p_dat) else $error("bad data");
    property p_idle; !reg_read |=> reg_rdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("bad idle");
    property p_rst; !$past(reset_n) |-> pin_oe == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_irq; irq |-> ie_q != 8'h00; endproperty
    a_irq: assert property (p_irq) else $error("bad irq");
    cover property (irq);
    cover property (rd1);
    cover property (pin_oe != 8'h00 && pin_out == 8'h00);
endmodule : gpio_port_asserts
bind gpio_port gpio_port_asserts chk (.*);

// >>> dv/board_model.sv
`timescale 1ns/10ps
module board_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Undriven pins float up to the board pull-up, so a released open-drain pin reads high.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_drive | ext_level));
endmodule : board_model

// >>> dv/tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, irq;
    logic [11:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [7:0] event_chan_a = 8'h33, event_chan_b = 8'hCC, ext_drive = '0, ext_level = '0;
    logic [7:0] timer_clear, pin_in, pin_out, pin_oe;
    int error_cnt = 0, checks = 0;
    gpio_port DUT (.*);
    board_model board (.*);
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd
    task automatic pins(input logic [7:0] oe, input logic [7:0] out);
        repeat (2) @(posedge clk);
        #1 `CHK(pin_oe, oe)
        `CHK(pin_out, out)
    endtask : pins
    task final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial forever #2.5 clk = ~clk;
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(12'h1E0, 32'h0000_0000);
        rd(12'h1E4, 32'h0000_00FF);
        $display("test reset done");
        wr(12'h1E0, 32'h0000_00FF);
        wr(12'h1E4, 32'h00FF_00A5);
        pins(8'hFF, 8'hA5);
        rd(12'h1E4, 32'h00FF_00A5);
        wr(12'h1E0, 32'h0000_0000);
        pins(8'h5A, 8'h00);
        $display("test data done");
        wr(12'h1E4, 32'h0000_0000);
        wr(12'h1E0, 32'hF00F_FFFF);
        pins(8'hFF, 8'h33);
        rd(12'h1E4, 32'h0000_0000);
        wr(12'h1E0, 32'hF00F_FF00);
        pins(8'hCC, 8'h00);
        $display("test event done");
        wr(12'h1E0, 32'h0000_0000);
        @(posedge clk);
        ext_drive <= 8'hFF;
        ext_level <= 8'hFE;
        repeat (8) @(posedge clk);
        wr(12'h1E8, 32'h0000_00FF);
        rd(12'h1E8, 32'h0000_0001);
        `CHK(timer_clear, 8'h01)
        `CHK(irq, 1'b0)
        wr(12'h1E8, 32'h0001_0000);
        #1 `CHK(irq, 1'b1)
        @(posedge clk);
        ext_level <= 8'hFF;
        repeat (8) @(posedge clk);
        wr(12'h1E8, 32'h0001_0001);
        rd(12'h1E8, 32'h0001_0000);
        `CHK(irq, 1'b0)
        rd(12'h1EC, 32'h0000_0000);
        $display("test irq done");
        final_report();
    end
endmodule : tb
